// *** logic/srsdl_pkg.sv ***
// Purpose: shared constants and carriers for sequence run/stop and drive lock control
// Assumes: 40 MHz hclk, AHB-Lite register access, single word transfers
// Notes: byte offsets are decoded on haddr[7:0]
package srsdl_pkg;

    // register byte offsets
    localparam logic [7:0] SRSDL_OFF_CFG = 8'h00;
    localparam logic [7:0] SRSDL_OFF_REMOTE = 8'h04;
    localparam logic [7:0] SRSDL_OFF_RELAY = 8'h08;
    localparam logic [7:0] SRSDL_OFF_AUTO = 8'h0C;
    localparam logic [7:0] SRSDL_OFF_DEVDATA = 8'h10;
    localparam logic [7:0] SRSDL_OFF_STATUS = 8'h14;
    localparam logic [7:0] SRSDL_OFF_INFN_FIRST = 8'h20;
    localparam logic [7:0] SRSDL_OFF_INFN_LAST = 8'h4C;
    localparam int SRSDL_INFN_COUNT = 12;

    // input terminal function code for the run request
    localparam logic [7:0] SRSDL_FN_SEQ_RUN = 8'h32;

    // enable selection codes
    localparam logic [3:0] SRSDL_PLC_OFF = 4'h0;
    localparam logic [3:0] SRSDL_PLC_SRC_A = 4'h1;
    localparam logic [3:0] SRSDL_PLC_TERM_A = 4'h2;
    localparam logic [3:0] SRSDL_PLC_SRC_B = 4'hB;
    localparam logic [3:0] SRSDL_PLC_TERM_B = 4'hC;

    // config fields
    localparam int SRSDL_CFG_PLC_LSB = 0;
    localparam int SRSDL_CFG_PLC_W = 4;
    localparam int SRSDL_CFG_SRC_BIT = 4;
    localparam int SRSDL_CFG_LOCK_BIT = 5;
    localparam int SRSDL_CFG_WPROT_BIT = 6;
    localparam int SRSDL_REM_EN_BIT = 0;
    localparam int SRSDL_REM_RUN_BIT = 1;
    localparam int SRSDL_AUTO_FWD_BIT = 0;
    localparam int SRSDL_AUTO_REV_BIT = 1;
    localparam int SRSDL_AUTO_W = 16;
    localparam int SRSDL_RELAY_W = 7;
    localparam int SRSDL_RELAY_SAVED_LSB = 16;

    // status fields
    localparam int SRSDL_ST_RUN_BIT = 0;
    localparam int SRSDL_ST_ENABLED_BIT = 1;
    localparam int SRSDL_ST_DECEL_BIT = 2;
    localparam int SRSDL_ST_DRIVE_BIT = 3;
    localparam int SRSDL_ST_REQ_BIT = 4;

    // reset values
    localparam logic [3:0] SRSDL_RST_PLC = 4'h0;
    localparam logic SRSDL_RST_LOCK = 1'b0;

    // timing
    localparam longint SRSDL_CLK_HZ = 40000000;
    localparam longint SRSDL_RESET_HOLD_US = 100000;
    localparam longint SRSDL_SCAN_US = 10;
    localparam longint SRSDL_RESET_HOLD_CYCLES = (SRSDL_CLK_HZ / 1000000) * SRSDL_RESET_HOLD_US;
    localparam longint SRSDL_SCAN_CYCLES = (SRSDL_CLK_HZ / 1000000) * SRSDL_SCAN_US;

    // ahb transfer types
    localparam logic [1:0] SRSDL_HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } srsdl_ahb_in_type;

    typedef struct packed {
        logic start_fwd;
        logic start_rev;
        logic decel_stop;
    } srsdl_drive_cmd_type;

endpackage

// *** logic/srsdl_scan_tick.sv ***
// Purpose: program scan boundary tick divider
// Assumes: single hclk domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
module srsdl_scan_tick #(
    parameter int SCAN_CYCLES = 400
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // tick
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } srsdl_scan_state_type;

    srsdl_scan_state_type st_reg;
    srsdl_scan_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= 32'(SCAN_CYCLES - 1)) begin
            st_next.cnt = 32'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule

// *** logic/srsdl_reset_hold.sv ***
// Purpose: qualifies the drive reset input as a long pulse
// Assumes: input synchronous to hclk
// Notes: clear fires once on release after a long enough hold
`timescale 1ns/1ps
module srsdl_reset_hold #(
    parameter int HOLD_CYCLES = 4000000
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // reset terminal
    input wire logic level,
    // result
    output logic clear_pulse
);
    typedef struct packed {
        logic [31:0] cnt;
        logic held;
        logic pulse;
    } srsdl_hold_state_type;

    srsdl_hold_state_type st_reg;
    srsdl_hold_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        if (level) begin
            if (st_reg.cnt < 32'(HOLD_CYCLES)) begin
                st_next.cnt = st_reg.cnt + 32'h1;
            end else begin
                st_next.held = 1'b1;
            end
        end else begin
            // short glitches never clear retained data
            st_next.pulse = st_reg.held;
            st_next.held = 1'b0;
            st_next.cnt = 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign clear_pulse = st_reg.pulse;
endmodule

// *** logic/srsdl_top.sv ***
// Purpose: sequence program run/stop control and drive start lock
// Assumes: AHB-Lite slave, inputs synchronous to hclk
// Notes: reads take one wait state, writes none
`timescale 1ns/1ps
module srsdl_top #(
    parameter int RELAY_W = srsdl_pkg::SRSDL_RELAY_W,
    parameter int TERM_COUNT = srsdl_pkg::SRSDL_INFN_COUNT,
    parameter int RESET_HOLD_CYCLES = int'(srsdl_pkg::SRSDL_RESET_HOLD_CYCLES),
    parameter int SCAN_CYCLES = int'(srsdl_pkg::SRSDL_SCAN_CYCLES)
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire srsdl_pkg::srsdl_ahb_in_type ahb_in,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // input terminals
    input wire logic [TERM_COUNT-1:0] term_in,
    input wire logic net_virtual_input,
    input wire logic drive_reset_input,
    // drive start sources
    input wire logic term_start_fwd,
    input wire logic term_start_rev,
    input wire logic panel_start_fwd,
    input wire logic panel_start_rev,
    input wire logic drive_running,
    // drive and relay outputs
    output srsdl_pkg::srsdl_drive_cmd_type drive_cmd,
    output logic [RELAY_W-1:0] relay_out,
    output logic seq_running
);
    typedef struct packed {
        logic [3:0] plc_enable_select;
        logic command_source_select;
        logic drive_lock_select;
        logic param_write_protect_select;
        logic remote_en;
        logic remote_run;
        logic [RELAY_W-1:0] relay_img;
        logic [RELAY_W-1:0] saved_relay;
        logic [RELAY_W-1:0] relay_out;
        logic [srsdl_pkg::SRSDL_AUTO_W-1:0] auto_run_command_word;
        logic [31:0] devdata;
        logic [TERM_COUNT-1:0][7:0] input_function_selects;
        logic req_s1;
        logic req_s2;
        logic run;
        logic decel;
        srsdl_pkg::srsdl_drive_cmd_type cmd;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rd_pend;
        logic [7:0] rd_addr;
        logic hready;
        logic [31:0] hrdata;
    } srsdl_main_state_type;

    srsdl_main_state_type st_reg;
    srsdl_main_state_type st_next;
    logic scan_tick;
    logic data_clear;
    logic [TERM_COUNT-1:0] term_is_req;
    logic phys_req;
    logic seq_run_request;
    logic plc_enabled;
    logic start_allow;
    logic addr_take;

    // permitted, non-zero enable code
    function automatic logic plc_on(input logic [3:0] sel);
        plc_on = (sel == srsdl_pkg::SRSDL_PLC_SRC_A) || (sel == srsdl_pkg::SRSDL_PLC_SRC_B) ||
                 (sel == srsdl_pkg::SRSDL_PLC_TERM_A) || (sel == srsdl_pkg::SRSDL_PLC_TERM_B);
    endfunction

    function automatic logic sel_valid(input logic [3:0] sel);
        sel_valid = (sel == srsdl_pkg::SRSDL_PLC_OFF) || plc_on(sel);
    endfunction

    function automatic logic is_infn(input logic [7:0] a);
        is_infn = (a >= srsdl_pkg::SRSDL_OFF_INFN_FIRST) && (a <= srsdl_pkg::SRSDL_OFF_INFN_LAST) &&
                  (a[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] infn_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - srsdl_pkg::SRSDL_OFF_INFN_FIRST;
        infn_index = d[5:2];
    endfunction

    srsdl_scan_tick #(
        .SCAN_CYCLES(SCAN_CYCLES)
    ) u_scan (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(scan_tick)
    );

    srsdl_reset_hold #(
        .HOLD_CYCLES(RESET_HOLD_CYCLES)
    ) u_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(drive_reset_input),
        .clear_pulse(data_clear)
    );

    // terminals whose function carries the run request
    genvar gi;
    generate
        for (gi = 0; gi < TERM_COUNT; gi++) begin : g_term
            assign term_is_req[gi] = term_in[gi] &&
                (st_reg.input_function_selects[gi] == srsdl_pkg::SRSDL_FN_SEQ_RUN);
        end
    endgenerate

    assign phys_req = |term_is_req;
    assign plc_enabled = plc_on(st_reg.plc_enable_select);

    always_comb begin
        seq_run_request = 1'b0;
        if (!plc_enabled) begin
            seq_run_request = 1'b0;
        end else if (st_reg.remote_en) begin
            seq_run_request = st_reg.remote_run;
        end else if ((st_reg.plc_enable_select == srsdl_pkg::SRSDL_PLC_TERM_A) ||
                     (st_reg.plc_enable_select == srsdl_pkg::SRSDL_PLC_TERM_B)) begin
            seq_run_request = phys_req;
        end else if (!st_reg.command_source_select) begin
            // network input alone is enough, no terminal needed
            seq_run_request = phys_req | net_virtual_input;
        end else begin
            seq_run_request = phys_req;
        end
    end

    // lock at 0 lets every start through
    assign start_allow = !st_reg.drive_lock_select || st_reg.run;
    assign addr_take = ahb_in.hsel && ahb_in.hready && (ahb_in.htrans == srsdl_pkg::SRSDL_HTRANS_NONSEQ);

    always_comb begin
        logic [31:0] rd;
        logic [7:0] a;
        logic [31:0] w;
        rd = 32'h0;
        a = st_reg.rd_addr;
        w = ahb_in.hwdata;
        st_next = st_reg;

        // run request sync, applied only on scan boundary
        st_next.req_s1 = seq_run_request;
        st_next.req_s2 = st_reg.req_s1;
        if (scan_tick) begin
            st_next.run = st_reg.req_s2;
            if (st_reg.run && !st_reg.req_s2) begin
                st_next.saved_relay = st_reg.relay_img;
                if (st_reg.drive_lock_select && drive_running) begin
                    st_next.decel = 1'b1;
                end
            end
        end
        if (!drive_running || st_next.run) begin
            st_next.decel = 1'b0;
        end
        st_next.relay_out = st_next.run ? st_reg.relay_img : '0;

        // drive starts, panel and automatic command gated alike
        st_next.cmd.start_fwd = start_allow && !st_next.decel && (term_start_fwd || panel_start_fwd ||
            st_reg.auto_run_command_word[srsdl_pkg::SRSDL_AUTO_FWD_BIT]);
        st_next.cmd.start_rev = start_allow && !st_next.decel && (term_start_rev || panel_start_rev ||
            st_reg.auto_run_command_word[srsdl_pkg::SRSDL_AUTO_REV_BIT]);
        st_next.cmd.decel_stop = st_next.decel;

        // register write data phase
        if (st_reg.wr_pend) begin
            if (st_reg.wr_addr == srsdl_pkg::SRSDL_OFF_CFG) begin
                if (sel_valid(w[srsdl_pkg::SRSDL_CFG_PLC_LSB +: srsdl_pkg::SRSDL_CFG_PLC_W])) begin
                    st_next.plc_enable_select = w[srsdl_pkg::SRSDL_CFG_PLC_LSB +: srsdl_pkg::SRSDL_CFG_PLC_W];
                end
                st_next.command_source_select = w[srsdl_pkg::SRSDL_CFG_SRC_BIT];
                st_next.param_write_protect_select = w[srsdl_pkg::SRSDL_CFG_WPROT_BIT];
                // refused while operating, write protection not consulted
                if (!drive_running) begin
                    st_next.drive_lock_select = w[srsdl_pkg::SRSDL_CFG_LOCK_BIT];
                end
            end else if (st_reg.wr_addr == srsdl_pkg::SRSDL_OFF_REMOTE) begin
                st_next.remote_en = w[srsdl_pkg::SRSDL_REM_EN_BIT];
                st_next.remote_run = w[srsdl_pkg::SRSDL_REM_RUN_BIT];
            end else if (st_reg.wr_addr == srsdl_pkg::SRSDL_OFF_RELAY) begin
                st_next.relay_img = w[RELAY_W-1:0];
            end else if (st_reg.wr_addr == srsdl_pkg::SRSDL_OFF_AUTO) begin
                st_next.auto_run_command_word = w[srsdl_pkg::SRSDL_AUTO_W-1:0];
            end else if (st_reg.wr_addr == srsdl_pkg::SRSDL_OFF_DEVDATA) begin
                if (!st_reg.run) begin
                    st_next.devdata = w;
                end
            end else if (is_infn(st_reg.wr_addr)) begin
                if (!st_reg.run) begin
                    st_next.input_function_selects[infn_index(st_reg.wr_addr)] = w[7:0];
                end
            end
        end

        // long reset pulse clears retained data; stop alone keeps it
        if (data_clear) begin
            st_next.devdata = 32'h0;
            st_next.auto_run_command_word = '0;
            st_next.relay_img = '0;
            st_next.saved_relay = '0;
        end

        // address phase; reads get one wait state so writes settle first
        st_next.wr_pend = 1'b0;
        if (st_reg.rd_pend) begin
            case (1'b1)
                (a == srsdl_pkg::SRSDL_OFF_CFG): begin
                    rd[srsdl_pkg::SRSDL_CFG_PLC_LSB +: srsdl_pkg::SRSDL_CFG_PLC_W] = st_reg.plc_enable_select;
                    rd[srsdl_pkg::SRSDL_CFG_SRC_BIT] = st_reg.command_source_select;
                    rd[srsdl_pkg::SRSDL_CFG_LOCK_BIT] = st_reg.drive_lock_select;
                    rd[srsdl_pkg::SRSDL_CFG_WPROT_BIT] = st_reg.param_write_protect_select;
                end
                (a == srsdl_pkg::SRSDL_OFF_REMOTE): begin
                    rd[srsdl_pkg::SRSDL_REM_EN_BIT] = st_reg.remote_en;
                    rd[srsdl_pkg::SRSDL_REM_RUN_BIT] = st_reg.remote_run;
                end
                (a == srsdl_pkg::SRSDL_OFF_RELAY): begin
                    rd[RELAY_W-1:0] = st_reg.relay_img;
                    rd[srsdl_pkg::SRSDL_RELAY_SAVED_LSB +: RELAY_W] = st_reg.saved_relay;
                end
                (a == srsdl_pkg::SRSDL_OFF_AUTO): begin
                    rd[srsdl_pkg::SRSDL_AUTO_W-1:0] = st_reg.auto_run_command_word;
                end
                (a == srsdl_pkg::SRSDL_OFF_DEVDATA): begin
                    rd = st_reg.run ? 32'h0 : st_reg.devdata;
                end
                (a == srsdl_pkg::SRSDL_OFF_STATUS): begin
                    rd[srsdl_pkg::SRSDL_ST_RUN_BIT] = st_reg.run;
                    rd[srsdl_pkg::SRSDL_ST_ENABLED_BIT] = plc_enabled;
                    rd[srsdl_pkg::SRSDL_ST_DECEL_BIT] = st_reg.decel;
                    rd[srsdl_pkg::SRSDL_ST_DRIVE_BIT] = drive_running;
                    rd[srsdl_pkg::SRSDL_ST_REQ_BIT] = st_reg.req_s2;
                end
                is_infn(a): begin
                    rd[7:0] = st_reg.run ? 8'h0 : st_reg.input_function_selects[infn_index(a)];
                end
                default: begin
                    rd = 32'h0;
                end
            endcase
            st_next.hrdata = rd;
            st_next.rd_pend = 1'b0;
            st_next.hready = 1'b1;
        end else if (addr_take) begin
            st_next.wr_pend = ahb_in.hwrite;
            st_next.wr_addr = ahb_in.haddr[7:0];
            st_next.rd_pend = !ahb_in.hwrite;
            st_next.rd_addr = ahb_in.haddr[7:0];
            st_next.hready = ahb_in.hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.plc_enable_select <= srsdl_pkg::SRSDL_RST_PLC;
            st_reg.drive_lock_select <= srsdl_pkg::SRSDL_RST_LOCK;
            st_reg.hready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.hready;
    assign hresp = 1'b0;
    assign hrdata = st_reg.hrdata;
    assign drive_cmd = st_reg.cmd;
    assign relay_out = st_reg.relay_out;
    assign seq_running = st_reg.run;
endmodule

// *** dv/srsdl_props.sv ***
// Purpose: port checker for srsdl_top
// Assumes: one hclk domain, hresetn async active low
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module srsdl_props #(
    parameter int RELAY_W = 7,
    parameter int TERM_COUNT = 12,
    parameter int RESET_HOLD_CYCLES = 20,
    parameter int SCAN_CYCLES = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire srsdl_pkg::srsdl_ahb_in_type ahb_in,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // terminals
    input wire logic [TERM_COUNT-1:0] term_in,
    input wire logic net_virtual_input,
    input wire logic drive_reset_input,
    input wire logic term_start_fwd,
    input wire logic term_start_rev,
    input wire logic panel_start_fwd,
    input wire logic panel_start_rev,
    input wire logic drive_running,
    // outputs
    input wire srsdl_pkg::srsdl_drive_cmd_type drive_cmd,
    input wire logic [RELAY_W-1:0] relay_out,
    input wire logic seq_running
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [15:0] since_reg;
    // cycles since the run state last moved, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_reg <= 16'hFFFF;
        end else if ($changed(seq_running)) begin
            since_reg <= 16'h0000;
        end else if (since_reg != 16'hFFFF) begin
            since_reg <= since_reg + 16'h0001;
        end
    end
    property p_scan; $changed(seq_running) |-> since_reg >= SCAN_CYCLES - 1; endproperty
    a_scan: assert property (p_scan) else $error("run state moved off a scan boundary");
    property p_relay_off; !seq_running |-> relay_out == '0; endproperty
    a_relay_off: assert property (p_relay_off) else $error("relay on while stopped");
    property p_relay_chg; $changed(relay_out) |-> seq_running || $fell(seq_running); endproperty
    a_relay_chg: assert property (p_relay_chg) else $error("relay moved while stopped");
    property p_decel_stop; $rose(drive_cmd.decel_stop) |-> !seq_running; endproperty
    a_decel_stop: assert property (p_decel_stop) else $error("decel raised in run");
    property p_decel_drv; $rose(drive_cmd.decel_stop) |-> $past(drive_running); endproperty
    a_decel_drv: assert property (p_decel_drv) else $error("decel raised with drive idle");
    property p_decel_clr; !drive_running |=> !drive_cmd.decel_stop; endproperty
    a_decel_clr: assert property (p_decel_clr) else $error("decel held with drive idle");
    property p_rd_wait;
        ahb_in.hsel && ahb_in.hready && ahb_in.htrans == srsdl_pkg::SRSDL_HTRANS_NONSEQ && !ahb_in.hwrite
            |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
    property p_okay; !hreadyout |-> hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response on wait");
    c_run: cover property ($rose(seq_running));
    c_decel: cover property ($rose(drive_cmd.decel_stop));
    c_start: cover property ($rose(drive_cmd.start_rev));
endmodule

bind srsdl_top srsdl_props #(.RELAY_W(RELAY_W), .TERM_COUNT(TERM_COUNT),
    .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES), .SCAN_CYCLES(SCAN_CYCLES)) u_srsdl_props (
    .hclk, .hresetn, .ahb_in, .hreadyout, .hresp, .hrdata, .term_in, .net_virtual_input,
    .drive_reset_input, .term_start_fwd, .term_start_rev, .panel_start_fwd, .panel_start_rev,
    .drive_running, .drive_cmd, .relay_out, .seq_running);

// *** dv/srsdl_src_model.sv ***
// Purpose: terminal and network source model
// Assumes: terminal 0 carries the run request
// Notes: unassigned terminals toggle every cycle
`timescale 1ns/1ps
module srsdl_src_model (
    // clock
    input wire logic hclk,
    // requests from bench
    input wire logic phys_req,
    input wire logic net_req,
    // terminal side
    output logic [11:0] term_in = 12'h000,
    output logic net_virtual_input = 1'b0,
    output logic drive_reset_input = 1'b0
);
    logic [10:0] idle_reg = 11'h2AA;
    // toggling so a stray terminal can never pass for the request
    always @(posedge hclk) begin
        idle_reg <= ~idle_reg;
        term_in <= {idle_reg, phys_req};
        net_virtual_input <= net_req;
    end
    // hold for n cycles then release; only a long enough hold clears
    task automatic pulse_reset(input int n);
        drive_reset_input <= 1'b1;
        repeat (n) @(posedge hclk);
        drive_reset_input <= 1'b0;
    endtask
endmodule

// *** dv/srsdl_top_tb.sv ***
// Purpose: self-checking bench for srsdl_top
// Assumes: scan 8 cycles, reset hold 20 cycles
// Notes: table of source cases, then hand tests
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module srsdl_top_tb;
    typedef struct packed {logic [3:0] plc; logic src; logic ph; logic nt; logic ex;} srsdl_row_type;
    srsdl_row_type rows [10] = '{'{4'h0, 0, 1, 1, 0}, '{4'h1, 0, 0, 1, 1}, '{4'h1, 1, 0, 1, 0},
        '{4'h1, 1, 1, 0, 1}, '{4'hB, 0, 1, 0, 1}, '{4'hB, 1, 0, 1, 0}, '{4'h2, 0, 0, 1, 0},
        '{4'hC, 0, 1, 0, 1}, '{4'hC, 0, 0, 1, 0}, '{4'h2, 1, 1, 0, 1}};
    logic hclk = 0;
    logic hresetn = 0;
    srsdl_pkg::srsdl_ahb_in_type bm = '0;
    logic hreadyout, hresp, seq_running;
    logic [31:0] hrdata, q;
    logic phys = 0, net = 0, ts_f = 0, ts_r = 0, ps_f = 0, ps_r = 0, drv = 0;
    logic [11:0] term_in;
    logic net_vi, drst;
    srsdl_pkg::srsdl_drive_cmd_type drive_cmd;
    logic [6:0] relay_out;
    int fail_count = 0;
    int compares = 0;
    always #12.5 hclk = ~hclk;
    srsdl_top #(.RESET_HOLD_CYCLES(20), .SCAN_CYCLES(8)) u_srsdl_top (.hclk(hclk), .hresetn(hresetn),
        .ahb_in({bm.hsel, bm.haddr, bm.htrans, bm.hwrite, bm.hsize, hreadyout, bm.hwdata}),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .term_in(term_in),
        .net_virtual_input(net_vi), .drive_reset_input(drst), .term_start_fwd(ts_f),
        .term_start_rev(ts_r), .panel_start_fwd(ps_f), .panel_start_rev(ps_r),
        .drive_running(drv), .drive_cmd(drive_cmd), .relay_out(relay_out), .seq_running(seq_running));
    srsdl_src_model u_srsdl_src_model (.hclk(hclk), .phys_req(phys), .net_req(net), .term_in(term_in),
        .net_virtual_input(net_vi), .drive_reset_input(drst));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        bm.hsel <= 1'b1;
        bm.haddr <= {24'h000000, a};
        bm.htrans <= srsdl_pkg::SRSDL_HTRANS_NONSEQ;
        bm.hwrite <= w;
        bm.hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        bm.htrans <= 2'h0;
        bm.hsel <= 1'b0;
        bm.hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic cfg(input logic [3:0] plc, input logic src, input logic lock);
        xfer(1'b1, 8'h00, {25'h0000000, 1'b0, lock, src, plc});
    endtask
    // two sync flops plus a full scan, with margin
    task automatic run_wait();
        repeat (24) @(posedge hclk);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge hclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b1, 8'h20, 32'h00000032);
        xfer(1'b1, 8'h08, 32'h00000055);
        foreach (rows[i]) begin
            cfg(rows[i].plc, rows[i].src, 1'b0);
            phys <= rows[i].ph;
            net <= rows[i].nt;
            run_wait();
            `CHK("seq_running", rows[i].ex, seq_running)
            `CHK("relay_out", rows[i].ex ? 7'h55 : 7'h00, relay_out)
        end
        $display("source table done");
        phys <= 1'b0;
        cfg(4'h2, 1'b0, 1'b1);
        ps_f <= 1'b1;
        run_wait();
        `CHK("start_fwd stop", 1'b0, drive_cmd.start_fwd)
        phys <= 1'b1;
        run_wait();
        `CHK("start_fwd run", 1'b1, drive_cmd.start_fwd)
        drv <= 1'b1;
        phys <= 1'b0;
        run_wait();
        `CHK("decel_stop", 1'b1, drive_cmd.decel_stop)
        `CHK("relay_out off", 7'h00, relay_out)
        xfer(1'b0, 8'h08, 32'h0);
        `CHK("saved relays", 7'h55, q[22:16])
        xfer(1'b1, 8'h00, 32'h00000042);
        xfer(1'b0, 8'h00, 32'h0);
        `CHK("cfg lock held", 32'h00000062, q)
        drv <= 1'b0;
        ps_f <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK("decel clear", 1'b0, drive_cmd.decel_stop)
        cfg(4'h2, 1'b0, 1'b0);
        ts_r <= 1'b1;
        repeat (3) @(posedge hclk);
        `CHK("start_rev unlocked", 1'b1, drive_cmd.start_rev)
        ts_r <= 1'b0;
        xfer(1'b1, 8'h0C, 32'h00000001);
        repeat (3) @(posedge hclk);
        `CHK("auto lock 0", 1'b1, drive_cmd.start_fwd)
        cfg(4'h2, 1'b0, 1'b1);
        repeat (3) @(posedge hclk);
        `CHK("auto lock 1", 1'b0, drive_cmd.start_fwd)
        xfer(1'b1, 8'h0C, 32'h0);
        $display("lock tests done");
        xfer(1'b1, 8'h04, 32'h00000003);
        run_wait();
        `CHK("remote run", 1'b1, seq_running)
        xfer(1'b1, 8'h04, 32'h00000001);
        run_wait();
        `CHK("remote stop", 1'b0, seq_running)
        xfer(1'b1, 8'h04, 32'h0);
        xfer(1'b1, 8'h10, 32'hA5A5A5A5);
        phys <= 1'b1;
        run_wait();
        xfer(1'b1, 8'h10, 32'h0);
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("devdata in run", 32'h0, q)
        phys <= 1'b0;
        run_wait();
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("devdata kept", 32'hA5A5A5A5, q)
        u_srsdl_src_model.pulse_reset(5);
        repeat (4) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("devdata short", 32'hA5A5A5A5, q)
        u_srsdl_src_model.pulse_reset(25);
        repeat (4) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("devdata cleared", 32'h0, q)
        xfer(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 32'h0, q)
        $display("retention tests done");
        phys <= 1'b1;
        run_wait();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("run in reset", 1'b0, seq_running)
        hresetn <= 1'b1;
        xfer(1'b0, 8'h00, 32'h0);
        `CHK("cfg reset", 32'h0, q)
        $display("reset test done");
        tally_and_finish();
    end
endmodule
